/* arp_readout_port.sv */
// result read-out port: parallel, byte and serial access to six results
`timescale 1ns/1ns
`include "arp_regs.svh"
module arp_readout_port #(
    parameter int CONV_US_CYCLES = `ARP_US_NS / `ARP_MCLK_NS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host strobes, asynchronous pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic sclk,
    // host conversion control, asynchronous pins
    input wire logic conv_start_a,
    input wire logic conv_start_b,
    input wire logic [2:0] averaging_ratio_sel,
    // interface mode straps, asynchronous pins
    input wire logic serial_mode_sel,
    input wire logic byte_mode_sel,
    // analog front end samples
    input wire logic [`ARP_NUM_CH*`ARP_WORD_W-1:0] sample_flat,
    // parallel and byte result bus
    output logic [15:0] parallel_result_bus,
    output logic parallel_result_bus_oe_hi,
    output logic parallel_result_bus_oe_lo,
    // serial outputs
    output logic serial_out_a,
    output logic serial_out_b,
    output logic serial_oe,
    // first-word marker
    output logic first_word_flag,
    output logic first_word_flag_oe,
    // conversion status
    output logic busy
);
    import arp_pkg::*;

    localparam int SER_W = 3 * `ARP_WORD_W;

    // whole port state
    typedef struct packed {
        arp_rd_state_t st;
        logic [`ARP_SY_W-1:0] sy1;   // first synchroniser stage, read only by sy2
        logic [`ARP_SY_W-1:0] sy2;   // settled pin levels
        logic [`ARP_SY_W-1:0] sy3;   // previous settled levels for edges
        logic [2:0] ptr;             // next channel word to present
        logic half;                  // byte mode: low byte next
        logic byte_m;                // byte mode latched at select fall
        logic [5:0] bitcnt;          // serial clock falls seen in this frame
        logic [SER_W-1:0] sh_a;      // channels 1..3 shifted out on line a
        logic [SER_W-1:0] sh_b;      // channels 4..6 shifted out on line b
        logic [15:0] db;             // parallel bus data
        logic flag;                  // marker level
    } arp_rd_t;

    arp_rd_t rd_reg;
    arp_rd_t rd_next;

    // conversion engine wiring
    logic conv_go;
    logic [`ARP_NUM_CH*`ARP_WORD_W-1:0] result_flat;

    // pick one channel's word out of the result vector
    function automatic logic [15:0] word_of(input logic [`ARP_NUM_CH*`ARP_WORD_W-1:0] r,
                                            input logic [2:0] idx);
        word_of = r[idx*`ARP_WORD_W +: `ARP_WORD_W];
    endfunction

    // edge helpers on the settled stages only
    function automatic logic fell(input arp_rd_t s, input int b);
        fell = s.sy3[b] & ~s.sy2[b];
    endfunction

    function automatic logic rose(input arp_rd_t s, input int b);
        rose = ~s.sy3[b] & s.sy2[b];
    endfunction

    // a start on either pin, ignored by the engine while busy
    assign conv_go = rose(rd_reg, `ARP_SY_CVA) | rose(rd_reg, `ARP_SY_CVB);

    // conversion engine
    arp_conv_core #(
        .US_CYCLES(CONV_US_CYCLES)
    ) u_core (
        .mclk(mclk),
        .rst(rst),
        .start(conv_go),
        .os_sel(rd_reg.sy2[`ARP_SY_OS +: 3]),
        .sample_flat(sample_flat),
        .busy(busy),
        .result_flat(result_flat)
    );

    // next-state logic of the host port
    always_comb begin
        logic cs_fall;
        logic cs_rise;
        logic rd_fall;
        logic [15:0] w;
        logic [15:0] w0;
        cs_fall = fell(rd_reg, `ARP_SY_CS);
        cs_rise = rose(rd_reg, `ARP_SY_CS);
        rd_fall = fell(rd_reg, `ARP_SY_RD);
        w = word_of(result_flat, rd_reg.ptr);
        w0 = word_of(result_flat, 3'h0); // first channel, for tied strobes
        rd_next = rd_reg;
        // two-stage synchroniser, then one more stage for edge finding
        rd_next.sy1 = {averaging_ratio_sel, byte_mode_sel, serial_mode_sel,
                       conv_start_b, conv_start_a, sclk, rd_n, cs_n};
        rd_next.sy2 = rd_reg.sy1;
        rd_next.sy3 = rd_reg.sy2;
        unique case (rd_reg.st)
            ARP_RD_IDLE: begin
                if (cs_fall) begin
                    if (rd_reg.sy2[`ARP_SY_SER]) begin
                        // serial: load both lines, first bit at once
                        rd_next.st = ARP_RD_SER;
                        rd_next.sh_a = {word_of(result_flat, 3'h0), word_of(result_flat, 3'h1),
                                        word_of(result_flat, 3'h2)};
                        rd_next.sh_b = {word_of(result_flat, 3'h3), word_of(result_flat, 3'h4),
                                        word_of(result_flat, 3'h5)};
                        rd_next.bitcnt = 6'h00;
                        rd_next.flag = 1'b1;
                    end else begin
                        rd_next.st = ARP_RD_PAR;
                        rd_next.byte_m = rd_reg.sy2[`ARP_SY_BYTE];
                        rd_next.half = 1'b0;
                        if (rd_fall) begin
                            // tied strobes: this fall is also the first read
                            rd_next.ptr = 3'h1;
                            rd_next.flag = 1'b1;
                            if (rd_reg.sy2[`ARP_SY_BYTE]) begin
                                rd_next.db = {8'h00, w0[15:8]};
                                rd_next.ptr = 3'h0;
                                rd_next.half = 1'b1;
                            end else begin
                                rd_next.db = word_of(result_flat, 3'h0);
                            end
                        end else begin
                            // separate strobes: marker low until the first read
                            rd_next.ptr = 3'h0;
                            rd_next.flag = 1'b0;
                            rd_next.db = `ARP_RST_WORD;
                        end
                    end
                end
            end
            ARP_RD_PAR: begin
                if (cs_rise) begin
                    // select rise ends the access for tied or separate strobes
                    rd_next.st = ARP_RD_IDLE;
                end else if (rd_fall) begin
                    rd_next.flag = (rd_reg.ptr == 3'h0);
                    if (rd_reg.byte_m) begin
                        // high byte first, then low byte of the same channel
                        rd_next.db = {8'h00, rd_reg.half ? w[7:0] : w[15:8]};
                        rd_next.half = ~rd_reg.half;
                        if (rd_reg.half) begin
                            rd_next.ptr = (rd_reg.ptr == `ARP_LAST_CH) ? 3'h0
                                                                      : rd_reg.ptr + 3'h1;
                        end
                    end else begin
                        rd_next.db = w;
                        // wraps to channel one after the sixth word
                        rd_next.ptr = (rd_reg.ptr == `ARP_LAST_CH) ? 3'h0 : rd_reg.ptr + 3'h1;
                    end
                end
            end
            ARP_RD_SER: begin
                if (cs_rise) begin
                    rd_next.st = ARP_RD_IDLE;
                end else begin
                    // new bit on each rising edge of the host clock
                    if (rose(rd_reg, `ARP_SY_SCLK)) begin
                        rd_next.sh_a = {rd_reg.sh_a[SER_W-2:0], 1'b0};
                        rd_next.sh_b = {rd_reg.sh_b[SER_W-2:0], 1'b0};
                    end
                    // count falls; marker drops after the sixteenth
                    if (fell(rd_reg, `ARP_SY_SCLK)) begin
                        rd_next.bitcnt = (rd_reg.bitcnt == 6'h3F) ? rd_reg.bitcnt
                                                                 : rd_reg.bitcnt + 6'h01;
                        if (rd_reg.bitcnt == `ARP_LAST_BIT) begin
                            rd_next.flag = 1'b0;
                        end
                    end
                end
            end
            default: begin
                // illegal code: park and release all pins
                rd_next.st = ARP_RD_IDLE;
            end
        endcase
    end

    // state register; select and read rest high, sclk low, so no false edge after reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_reg <= '{st: ARP_RD_IDLE, sy1: 10'h003, sy2: 10'h003, sy3: 10'h003,
                        db: `ARP_RST_WORD, default: '0};
        end else begin
            rd_reg <= rd_next;
        end
    end

    // pin drivers; the enables follow state so release is on the third clock edge after select rise
    assign parallel_result_bus = rd_reg.db;
    assign parallel_result_bus_oe_lo = (rd_reg.st == ARP_RD_PAR);
    assign parallel_result_bus_oe_hi = (rd_reg.st == ARP_RD_PAR) & ~rd_reg.byte_m;
    assign serial_out_a = rd_reg.sh_a[SER_W-1];
    assign serial_out_b = rd_reg.sh_b[SER_W-1];
    assign serial_oe = (rd_reg.st == ARP_RD_SER);
    assign first_word_flag = rd_reg.flag;
    assign first_word_flag_oe = (rd_reg.st != ARP_RD_IDLE);
endmodule

/* arp_regs.svh */
// timing counts, field positions and reset values of the result read-out port
`ifndef ARP_REGS_SVH
`define ARP_REGS_SVH

`define ARP_MCLK_NS 50
`define ARP_US_NS 1000
`define ARP_STEP_US 4
`define ARP_NUM_CH 6
`define ARP_WORD_W 16
`define ARP_ACC_W 22
`define ARP_OS_MAX 3'h6
`define ARP_RST_WORD 16'h0000
`define ARP_LAST_CH 3'h5
`define ARP_LAST_BIT 6'h0F
`define ARP_SY_W 10
`define ARP_SY_CS 0
`define ARP_SY_RD 1
`define ARP_SY_SCLK 2
`define ARP_SY_CVA 3
`define ARP_SY_CVB 4
`define ARP_SY_SER 5
`define ARP_SY_BYTE 6
`define ARP_SY_OS 7

`endif

/* arp_pkg.sv */
// shared state types of the result read-out port
package arp_pkg;
    `include "arp_regs.svh"

    // read-out port states, one-hot
    typedef enum logic [2:0] {
        ARP_RD_IDLE = 3'b001,
        ARP_RD_PAR = 3'b010,
        ARP_RD_SER = 3'b100
    } arp_rd_state_t;

    // conversion engine states, one-hot
    typedef enum logic [1:0] {
        ARP_CV_IDLE = 2'b01,
        ARP_CV_BUSY = 2'b10
    } arp_cv_state_t;
endpackage

/* arp_conv_core.sv */
// conversion engine: simultaneous snapshot, averaging and busy timing
`timescale 1ns/1ns
`include "arp_regs.svh"
module arp_conv_core #(
    parameter int US_CYCLES = `ARP_US_NS / `ARP_MCLK_NS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control from the read-out port
    input wire logic start,
    input wire logic [2:0] os_sel,
    // front end samples, same clock domain
    input wire logic [`ARP_NUM_CH*`ARP_WORD_W-1:0] sample_flat,
    // status and results
    output logic busy,
    output logic [`ARP_NUM_CH*`ARP_WORD_W-1:0] result_flat
);
    import arp_pkg::*;

    localparam logic [15:0] STEP_LEN = 16'(US_CYCLES * `ARP_STEP_US);

    // refuse rates that overflow the 16-bit busy counter, at elaboration
    if (US_CYCLES < 1 || US_CYCLES * 256 > 65535) begin
        $error("arp_conv_core: US_CYCLES out of range");
    end

    // whole engine state
    typedef struct packed {
        arp_cv_state_t st;
        logic [15:0] cnt;      // cycles since start
        logic [15:0] len;      // busy length of this conversion
        logic [15:0] step;     // cycles since last snapshot
        logic [6:0] left;      // snapshots still to add
        logic [2:0] os;        // ratio latched at start
        logic [`ARP_NUM_CH-1:0][`ARP_ACC_W-1:0] acc;
        logic [`ARP_NUM_CH*`ARP_WORD_W-1:0] res;
    } arp_cv_t;

    arp_cv_t cv_reg;
    arp_cv_t cv_next;

    // sign-extend one channel's sample to accumulator width
    function automatic logic [`ARP_ACC_W-1:0] sext(input logic [`ARP_WORD_W-1:0] v);
        sext = {{(`ARP_ACC_W-`ARP_WORD_W){v[`ARP_WORD_W-1]}}, v};
    endfunction

    // next-state logic
    always_comb begin
        logic signed [`ARP_ACC_W-1:0] avg;
        avg = '0;
        cv_next = cv_reg;
        unique case (cv_reg.st)
            ARP_CV_IDLE: begin
                // a start while busy is never seen here, which caps the rate
                if (start) begin
                    cv_next.st = ARP_CV_BUSY;
                    // unused code 111 falls back to no averaging
                    cv_next.os = (os_sel > `ARP_OS_MAX) ? 3'h0 : os_sel;
                    // shift amount taken as int: a 3-bit sum would wrap at ratio 64
                    cv_next.len = 16'((US_CYCLES << (int'(cv_next.os) + 2)) - US_CYCLES);
                    cv_next.cnt = 16'h0000;
                    cv_next.step = 16'h0000;
                    cv_next.left = 7'((1 << cv_next.os) - 1);
                    // every channel caught in the same cycle
                    for (int i = 0; i < `ARP_NUM_CH; i++) begin
                        cv_next.acc[i] = sext(sample_flat[i*`ARP_WORD_W +: `ARP_WORD_W]);
                    end
                end
            end
            ARP_CV_BUSY: begin
                cv_next.cnt = cv_reg.cnt + 16'h0001;
                cv_next.step = cv_reg.step + 16'h0001;
                // one more snapshot per conversion step while averaging
                if (cv_reg.step == STEP_LEN - 16'h0001) begin
                    cv_next.step = 16'h0000;
                    if (cv_reg.left != 7'h00) begin
                        cv_next.left = cv_reg.left - 7'h01;
                        for (int i = 0; i < `ARP_NUM_CH; i++) begin
                            cv_next.acc[i] = cv_reg.acc[i]
                                + sext(sample_flat[i*`ARP_WORD_W +: `ARP_WORD_W]);
                        end
                    end
                end
                // end of conversion: publish all six averages at once
                if (cv_reg.cnt == cv_reg.len - 16'h0001) begin
                    cv_next.st = ARP_CV_IDLE;
                    for (int i = 0; i < `ARP_NUM_CH; i++) begin
                        avg = $signed(cv_reg.acc[i]) >>> cv_reg.os;
                        cv_next.res[i*`ARP_WORD_W +: `ARP_WORD_W] = avg[`ARP_WORD_W-1:0];
                    end
                end
            end
            default: begin
                cv_next.st = ARP_CV_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            cv_reg <= '{st: ARP_CV_IDLE, default: '0};
        end else begin
            cv_reg <= cv_next;
        end
    end

    // busy straight from state, results from flip-flops
    assign busy = (cv_reg.st == ARP_CV_BUSY);
    assign result_flat = cv_reg.res;
endmodule

/* arp_readout_port_sva.sv */
// assertion checker for the result read-out port pins
`timescale 1ns/1ns
module arp_readout_port_sva #(
    parameter int CONV_US_CYCLES = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic sclk,
    input wire logic conv_start_a,
    input wire logic conv_start_b,
    input wire logic serial_mode_sel,
    input wire logic byte_mode_sel,
    // device pins
    input wire logic parallel_result_bus_oe_hi,
    input wire logic parallel_result_bus_oe_lo,
    input wire logic serial_out_a,
    input wire logic serial_oe,
    input wire logic first_word_flag,
    input wire logic first_word_flag_oe,
    input wire logic busy
);
    import arp_pkg::*;
    // helper state: busy run, cycles since sclk rise, sclk falls in frame
    typedef struct packed {
        logic [12:0] busy_len;
        logic [3:0] sclk_age;
        logic [5:0] falls;
        logic sclk_d;
    } arp_chk_t;
    arp_chk_t st_reg, st_next;
    logic [12:0] units; // busy length in microsecond steps
    assign units = st_reg.busy_len / 13'(CONV_US_CYCLES);
    // next helper state
    always_comb begin
        st_next = st_reg;
        st_next.sclk_d = sclk;
        st_next.busy_len = busy ? st_reg.busy_len + 13'h0001 : 13'h0000;
        // age saturates so a long idle never wraps back to small
        if (sclk && !st_reg.sclk_d) begin
            st_next.sclk_age = 4'h0;
        end else if (st_reg.sclk_age != 4'hF) begin
            st_next.sclk_age = st_reg.sclk_age + 4'h1;
        end
        // falls only count inside a selected frame
        if (cs_n) begin
            st_next.falls = 6'h00;
        end else if (st_reg.sclk_d && !sclk) begin
            st_next.falls = st_reg.falls + 6'h01;
        end
    end
    // register helper state
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_release_all: assert property ($rose(cs_n) |-> ##[1:5]
        !(parallel_result_bus_oe_lo || first_word_flag_oe || serial_oe))
        else $error("outputs not released after select rise");
    chk_par_drive: assert property ($fell(cs_n) && !serial_mode_sel |->
        ##[1:5] parallel_result_bus_oe_lo && first_word_flag_oe)
        else $error("parallel bus not driven after select fall");
    chk_ser_drive: assert property ($fell(cs_n) && serial_mode_sel |->
        ##[1:5] serial_oe && first_word_flag_oe)
        else $error("serial outputs not driven after select fall");
    chk_byte_lanes: assert property (parallel_result_bus_oe_hi |-> !byte_mode_sel)
        else $error("upper lanes driven in byte mode");
    chk_busy_start: assert property (!busy && ($rose(conv_start_a) ||
        $rose(conv_start_b)) |-> ##[2:5] busy)
        else $error("busy did not follow start edge");
    chk_busy_len: assert property ($fell(busy) |->
        st_reg.busy_len % 13'(CONV_US_CYCLES) == 13'h0000 && units >= 13'h0003 &&
        ((units + 13'h0001) & units) == 13'h0000)
        else $error("busy length off the conversion table");
    chk_ser_shift: assert property (serial_oe && $past(serial_oe) &&
        $changed(serial_out_a) |-> st_reg.sclk_age <= 4'h5)
        else $error("serial bit changed away from sclk rise");
    chk_flag_16: assert property (serial_oe && $fell(first_word_flag) |->
        st_reg.falls == 6'h10)
        else $error("marker fell off the sixteenth sclk fall");
    chk_flag_low: assert property ($rose(first_word_flag_oe) && rd_n && !serial_oe
        |-> !first_word_flag)
        else $error("marker not low at separate select fall");
    cover property ($fell(busy) && units == 13'h00FF);
    cover property ($fell(first_word_flag) && serial_oe);
    cover property ($rose(parallel_result_bus_oe_lo) && !rd_n);
endmodule

bind arp_readout_port arp_readout_port_sva #(.CONV_US_CYCLES(CONV_US_CYCLES))
    arp_readout_port_sva_i (.mclk(mclk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .sclk(sclk), .conv_start_a(conv_start_a), .conv_start_b(conv_start_b),
    .serial_mode_sel(serial_mode_sel), .byte_mode_sel(byte_mode_sel),
    .parallel_result_bus_oe_hi(parallel_result_bus_oe_hi),
    .parallel_result_bus_oe_lo(parallel_result_bus_oe_lo),
    .serial_out_a(serial_out_a), .serial_oe(serial_oe),
    .first_word_flag(first_word_flag), .first_word_flag_oe(first_word_flag_oe),
    .busy(busy));

/* arp_host_model.sv */
// host controller model driving the read-out port strobes
`timescale 1ns/1ns
module arp_host_model (
    // clock from the bench
    input wire logic mclk,
    // strobes and control to the device
    output logic cs_n,
    output logic rd_n,
    output logic sclk,
    output logic conv_start_a,
    output logic conv_start_b,
    output logic [2:0] averaging_ratio_sel
);
    import arp_pkg::*;
    // idle levels from time zero; sclk stands low outside frames
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        sclk = 1'b0;
        conv_start_a = 1'b0;
        conv_start_b = 1'b0;
        averaging_ratio_sel = 3'h0;
    end
    // wait falling edges; every level is held past the 3-cycle sync need
    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one start edge on either pin with a chosen ratio
    task automatic start(input logic sel_b, input logic [2:0] os);
        averaging_ratio_sel = os;
        if (sel_b) conv_start_b = 1'b1;
        else conv_start_a = 1'b1;
        gap(6);
        conv_start_a = 1'b0;
        conv_start_b = 1'b0;
    endtask
    // select, with read falling on the same edge when tied
    task automatic select(input logic tied);
        cs_n = 1'b0;
        rd_n = !tied;
        gap(6);
    endtask
    // one read strobe, low then high
    task automatic read();
        rd_n = 1'b0;
        gap(6);
        rd_n = 1'b1;
        gap(6);
    endtask
    // end of access
    task automatic deselect();
        cs_n = 1'b1;
        rd_n = 1'b1;
        gap(8);
    endtask
    // one 400 ns serial clock period
    task automatic sclk_cycle();
        sclk = 1'b1;
        gap(4);
        sclk = 1'b0;
        gap(4);
    endtask
endmodule

/* test_arp_readout_port.sv */
// self-checking bench for the result read-out port
`timescale 1ns/1ns
module test_arp_readout_port;
    import arp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic serial_mode_sel = 1'b0;
    logic byte_mode_sel = 1'b0;
    logic [95:0] sample_flat = '0;
    logic [95:0] conv_set = '0; // expected results of the last finished conversion
    logic cs_n, rd_n, sclk, conv_start_a, conv_start_b;
    logic [2:0] averaging_ratio_sel;
    logic [15:0] parallel_result_bus;
    logic parallel_result_bus_oe_hi, parallel_result_bus_oe_lo;
    logic serial_out_a, serial_out_b, serial_oe;
    logic first_word_flag, first_word_flag_oe, busy;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    // 20 MHz clock
    always #25 mclk = ~mclk;
    arp_host_model arp_host_model_i (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk),
        .conv_start_a(conv_start_a), .conv_start_b(conv_start_b),
        .averaging_ratio_sel(averaging_ratio_sel));
    // one microsecond step per cycle keeps the longest busy at 255 cycles
    arp_readout_port #(.CONV_US_CYCLES(1)) arp_readout_port_i (.mclk(mclk), .rst(rst),
        .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk), .conv_start_a(conv_start_a),
        .conv_start_b(conv_start_b), .averaging_ratio_sel(averaging_ratio_sel),
        .serial_mode_sel(serial_mode_sel), .byte_mode_sel(byte_mode_sel),
        .sample_flat(sample_flat), .parallel_result_bus(parallel_result_bus),
        .parallel_result_bus_oe_hi(parallel_result_bus_oe_hi),
        .parallel_result_bus_oe_lo(parallel_result_bus_oe_lo),
        .serial_out_a(serial_out_a), .serial_out_b(serial_out_b), .serial_oe(serial_oe),
        .first_word_flag(first_word_flag), .first_word_flag_oe(first_word_flag_oe),
        .busy(busy));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // expected result word of a channel, 0 is the first
    function automatic logic [15:0] word(input int ch);
        return conv_set[16*ch +: 16];
    endfunction
    // expected busy cycles for a ratio code; 111 counts as none
    function automatic int busy_cycles(input logic [2:0] os);
        return (os == 3'h7) ? 3 : (4 << os) - 1;
    endfunction
    // expected averages: set a once, set b for every later snapshot
    function automatic logic [95:0] avg_set(input logic [95:0] a, input logic [95:0] b,
                                            input logic [2:0] os);
        int s;
        logic [2:0] r;
        r = (os == 3'h7) ? 3'h0 : os;
        for (int c = 0; c < 6; c++) begin
            s = $signed(a[16*c +: 16]) + $signed(b[16*c +: 16]) * ((1 << r) - 1);
            avg_set[16*c +: 16] = 16'(s >>> r);
        end
    endfunction
    // one conversion on two random sample sets, busy length measured
    task automatic convert(input logic sel_b, input logic [2:0] os);
        int len;
        logic [95:0] first;
        len = 0;
        first = {$urandom, $urandom, $urandom};
        sample_flat = first;
        fork
            arp_host_model_i.start(sel_b, os);
        join_none
        while (busy !== 1'b1 && len < 20) begin
            @(negedge mclk);
            len++;
        end
        // first snapshot is in; later snapshots of an average see this set
        sample_flat = {$urandom, $urandom, $urandom};
        len = 0;
        while (busy === 1'b1 && len < 300) begin
            @(negedge mclk);
            len++;
        end
        check(16'(len), 16'(busy_cycles(os)));
        conv_set = avg_set(first, sample_flat, os);
        repeat (4) @(negedge mclk);
    endtask
    // parallel or byte access, separate or tied strobes
    task automatic par_read(input logic tied, input logic bytes);
        int ch;
        logic [15:0] w;
        byte_mode_sel = bytes;
        arp_host_model_i.select(tied);
        check(16'(parallel_result_bus_oe_lo), 16'h0001);
        check(16'(first_word_flag_oe), 16'h0001);
        check(16'(first_word_flag), 16'(tied));
        // tied strobes present channel one, in byte mode its high byte
        w = word(0);
        if (bytes) w = {8'h00, w[15:8]};
        if (tied) check(parallel_result_bus, w);
        if (tied) check(16'(parallel_result_bus_oe_hi), 16'(!bytes));
        for (int k = 0; k < (tied ? 0 : (bytes ? 14 : 7)); k++) begin
            arp_host_model_i.read();
            ch = bytes ? (k / 2) % 6 : k % 6;
            w = word(ch);
            if (bytes) w = {8'h00, (k % 2) ? w[7:0] : w[15:8]};
            if (bytes) check({8'h00, parallel_result_bus[7:0]}, w);
            else check(parallel_result_bus, w);
            check(16'(first_word_flag), 16'(ch == 0));
            check(16'(parallel_result_bus_oe_hi), 16'(!bytes));
        end
        arp_host_model_i.deselect();
        check({13'h0, parallel_result_bus_oe_hi, parallel_result_bus_oe_lo, first_word_flag_oe},
            16'h0000);
        byte_mode_sel = 1'b0;
    endtask
    // serial frame of 48 bits on both lines
    task automatic ser_read();
        int b;
        serial_mode_sel = 1'b1;
        arp_host_model_i.select(1'b0);
        check({14'h0, serial_oe, first_word_flag_oe}, 16'h0003);
        for (int k = 0; k < 48; k++) begin
            // msb first, channels in order along each line
            b = 16 * (k / 16) + 15 - k % 16;
            check(16'({serial_out_a, serial_out_b}), 16'({conv_set[b], conv_set[48 + b]}));
            check(16'(first_word_flag), 16'(k < 16));
            arp_host_model_i.sclk_cycle();
        end
        arp_host_model_i.deselect();
        check({14'h0, serial_oe, first_word_flag_oe}, 16'h0000);
        serial_mode_sel = 1'b0;
    endtask
    // verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, far above the roughly 1300 cycles of the run
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'hDC1E));
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 8; i++) convert(i[0], i[2:0]);
        par_read(1'b0, 1'b0);
        par_read(1'b1, 1'b0);
        par_read(1'b1, 1'b0);
        convert(1'b1, 3'h1);
        par_read(1'b0, 1'b1);
        par_read(1'b1, 1'b1);
        ser_read();
        tally_and_finish();
    end
endmodule
